// file: scan_port_pkg.sv
// constants, types and helpers shared by the boundary-scan test port
package scan_port_pkg;
	localparam int IR_W   = 4;
	localparam int ID_W   = 32;
	localparam int PIN_CAP = 3;
	localparam int PIN_UPD = 2;
	localparam int IN_CAP  = 1;
	localparam int MC_CAP  = 1;
	localparam int SYNC_W  = 2;
	localparam int TP_TCK = 0;
	localparam int TP_TMS = 1;
	localparam int TP_TDI = 2;
	localparam int TP_TDO = 3;
	localparam logic [IR_W-1:0] IR_EXTEST  = 4'h0;
	localparam logic [IR_W-1:0] IR_SAMPLE  = 4'h1;
	localparam logic [IR_W-1:0] IR_IDCODE  = 4'h2;
	localparam logic [IR_W-1:0] IR_PROGRAM = 4'h8;
	localparam logic [IR_W-1:0] IR_BYPASS  = 4'hF;
	localparam logic [IR_W-1:0] IR_CAPTURE = 4'h1;
	localparam logic [IR_W-1:0] IR_RESET   = IR_IDCODE;
	// arbitrary identification value; bit 0 set as the scan convention asks
	localparam logic [ID_W-1:0] ID_CODE_DEFAULT = 32'h0A5C_0001;

	typedef enum logic [3:0] {
		ST_RESET  = 4'h0,
		ST_IDLE   = 4'h1,
		ST_SEL_DR = 4'h3,
		ST_CAP_DR = 4'h2,
		ST_SH_DR  = 4'h6,
		ST_EX1_DR = 4'h7,
		ST_PA_DR  = 4'h5,
		ST_EX2_DR = 4'h4,
		ST_UP_DR  = 4'hC,
		ST_SEL_IR = 4'hD,
		ST_CAP_IR = 4'hF,
		ST_SH_IR  = 4'hE,
		ST_EX1_IR = 4'hA,
		ST_PA_IR  = 4'hB,
		ST_EX2_IR = 4'h9,
		ST_UP_IR  = 4'h8
	} tap_state_t;

	typedef struct packed {
		logic capture;
		logic shift;
		logic update;
	} cell_ctrl_t;

	typedef struct packed {
		logic tck;
		logic tms;
		logic tdi;
	} tap_pins_t;

	function automatic tap_state_t tap_next(input tap_state_t s, input logic tms);
		case (s)
			ST_RESET:  tap_next = tms ? ST_RESET  : ST_IDLE;
			ST_IDLE:   tap_next = tms ? ST_SEL_DR : ST_IDLE;
			ST_SEL_DR: tap_next = tms ? ST_SEL_IR : ST_CAP_DR;
			ST_CAP_DR: tap_next = tms ? ST_EX1_DR : ST_SH_DR;
			ST_SH_DR:  tap_next = tms ? ST_EX1_DR : ST_SH_DR;
			ST_EX1_DR: tap_next = tms ? ST_UP_DR  : ST_PA_DR;
			ST_PA_DR:  tap_next = tms ? ST_EX2_DR : ST_PA_DR;
			ST_EX2_DR: tap_next = tms ? ST_UP_DR  : ST_SH_DR;
			ST_UP_DR:  tap_next = tms ? ST_SEL_DR : ST_IDLE;
			ST_SEL_IR: tap_next = tms ? ST_RESET  : ST_CAP_IR;
			ST_CAP_IR: tap_next = tms ? ST_EX1_IR : ST_SH_IR;
			ST_SH_IR:  tap_next = tms ? ST_EX1_IR : ST_SH_IR;
			ST_EX1_IR: tap_next = tms ? ST_UP_IR  : ST_PA_IR;
			ST_PA_IR:  tap_next = tms ? ST_EX2_IR : ST_PA_IR;
			ST_EX2_IR: tap_next = tms ? ST_UP_IR  : ST_SH_IR;
			ST_UP_IR:  tap_next = tms ? ST_SEL_DR : ST_IDLE;
			default:   tap_next = ST_RESET;
		endcase
	endfunction

	// opcodes outside the supported set fall back to bypass
	function automatic logic [IR_W-1:0] legal_ir(input logic [IR_W-1:0] op);
		case (op)
			IR_EXTEST, IR_SAMPLE, IR_IDCODE, IR_PROGRAM: legal_ir = op;
			default: legal_ir = IR_BYPASS;
		endcase
	endfunction
endpackage

// file: boundary_cell.sv
// one boundary cell: capture/scan stages plus update stages
module boundary_cell #(
	parameter int NCAP = 3,
	parameter int NUPD = 2
) (
	input  wire logic                      sys_clk_i,
	input  wire logic                      rst_b_i,
	input  wire logic                      ce_i,
	input  wire scan_port_pkg::cell_ctrl_t ctrl_i,
	input  wire logic                      si_i,
	input  wire logic [NCAP-1:0]           cap_i,
	output logic                           so_o,
	output logic [NUPD-1:0]                upd_o
);
	import scan_port_pkg::*;

	logic [NCAP-1:0] cap;
	logic [NCAP-1:0] next_cap;
	logic [NUPD-1:0] next_upd;

	always_comb begin
		next_cap = cap;
		next_upd = upd_o;
		if (ctrl_i.capture) begin
			next_cap = cap_i;
		end else if (ctrl_i.shift) begin
			next_cap[0] = si_i;
			for (int i = 1; i < NCAP; i++) begin
				next_cap[i] = cap[i-1];
			end
		end
		if (ctrl_i.update) begin
			next_upd = cap[NUPD-1:0];
		end
	end

	always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			cap   <= '0;
			upd_o <= '0;
		end else if (ce_i) begin
			cap   <= next_cap;
			upd_o <= next_upd;
		end
	end

	assign so_o = cap[NCAP-1];
endmodule // boundary_cell

// file: boundary_scan_test_port.sv
// boundary-scan test port: pin sampling, port state machine, data paths and pin muxing
module boundary_scan_test_port #(
	parameter int                            IO_COUNT = 96,
	parameter int                            IN_COUNT = 4,
	parameter int                            MC_COUNT = 8,
	parameter int                            PROG_W   = 32,
	parameter logic [scan_port_pkg::ID_W-1:0] ID_CODE  = scan_port_pkg::ID_CODE_DEFAULT
) (
	input  wire logic                sys_clk_i,
	input  wire logic                rst_b_i,
	input  wire logic                ce_i,
	input  wire logic                port_en_i,
	input  wire logic                pu_sel_i,
	input  wire logic [3:0]          tp_pin_i,
	input  wire logic [3:0]          tp_core_out_i,
	input  wire logic [3:0]          tp_core_oe_i,
	output logic      [3:0]          tp_pin_out_o,
	output logic      [3:0]          tp_pin_oe_b_o,
	output logic      [3:0]          tp_core_in_o,
	input  wire logic [IN_COUNT-1:0] in_pin_i,
	output logic      [IN_COUNT-1:0] in_core_o,
	input  wire logic [IO_COUNT-1:0] io_pin_i,
	input  wire logic [IO_COUNT-1:0] io_core_out_i,
	input  wire logic [IO_COUNT-1:0] io_core_oe_i,
	output logic      [IO_COUNT-1:0] io_pin_out_o,
	output logic      [IO_COUNT-1:0] io_pin_oe_b_o,
	output logic      [IO_COUNT-1:0] io_core_in_o,
	input  wire logic [MC_COUNT-1:0] mc_i,
	output logic      [MC_COUNT-1:0] mc_test_o,
	output logic                     mc_force_o,
	output logic                     tms_pu_o,
	output logic                     tdi_pu_o,
	output logic      [PROG_W-1:0]   prog_word_o,
	output logic                     prog_valid_o
);
	import scan_port_pkg::*;

	localparam int SW    = 4 + IN_COUNT + IO_COUNT;
	localparam int CELLS = IN_COUNT + IO_COUNT + MC_COUNT;

	logic [1:0]        rst_sync;
	logic              rst_sys_b;
	logic [SW-1:0]     s1;
	logic [SW-1:0]     s2;
	logic              tck_d;
	tap_pins_t         pins;
	logic              rise;
	logic              fall;
	tap_state_t        state, next_state;
	logic [IR_W-1:0]   ir, next_ir, ir_sr, next_ir_sr;
	logic              byp, next_byp;
	logic [ID_W-1:0]   id_sr, next_id;
	logic [PROG_W-1:0] prog_sr, next_prog, next_prog_word;
	logic              next_prog_valid;
	logic              tdo_q, next_tdo, tdo_oe_b, next_tdo_oe_b;
	logic              sel_bsr, extest, dr_out;
	cell_ctrl_t        ctrl;
	logic [CELLS:0]    chain;
	logic [IO_COUNT-1:0] upd_out, upd_oe;
	logic [MC_COUNT-1:0] mc_upd;

	// power-up reset and a disabled port both put the port state machine in reset
	always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			rst_sync <= 2'h0;
		end else if (ce_i) begin
			rst_sync <= {rst_sync[0], 1'b1};
		end
	end
	assign rst_sys_b = rst_sync[1];

	// every pin and the test clock are asynchronous; s1 feeds only s2
	always_ff @(posedge sys_clk_i or negedge rst_sys_b) begin
		if (!rst_sys_b) begin
			s1    <= '0;
			s2    <= '0;
			tck_d <= 1'b0;
		end else if (ce_i) begin
			s1    <= {io_pin_i, in_pin_i, tp_pin_i};
			s2    <= s1;
			tck_d <= s2[TP_TCK];
		end
	end

	assign pins = '{tck: s2[TP_TCK], tms: s2[TP_TMS], tdi: s2[TP_TDI]};
	assign rise = pins.tck && !tck_d;
	assign fall = !pins.tck && tck_d;
	assign sel_bsr = (ir == IR_EXTEST) || (ir == IR_SAMPLE);
	assign extest  = port_en_i && (ir == IR_EXTEST);

	// every cell strobe comes from the state machine, one per test clock rise
	assign ctrl = '{capture: rise && sel_bsr && state == ST_CAP_DR,
			shift:   rise && sel_bsr && state == ST_SH_DR,
			update:  rise && sel_bsr && state == ST_UP_DR};

	assign chain[0] = pins.tdi;
	for (genvar i = 0; i < IN_COUNT; i++) begin : g_in
		boundary_cell #(.NCAP(IN_CAP), .NUPD(1)) u_cell (
			.sys_clk_i(sys_clk_i), .rst_b_i(rst_sys_b), .ce_i(ce_i), .ctrl_i(ctrl),
			.si_i(chain[i]), .cap_i(s2[4+i]), .so_o(chain[i+1]), .upd_o());
	end
	for (genvar i = 0; i < IO_COUNT; i++) begin : g_io
		boundary_cell #(.NCAP(PIN_CAP), .NUPD(PIN_UPD)) u_cell (
			.sys_clk_i(sys_clk_i), .rst_b_i(rst_sys_b), .ce_i(ce_i), .ctrl_i(ctrl),
			.si_i(chain[IN_COUNT+i]),
			.cap_i({s2[4+IN_COUNT+i], io_core_oe_i[i], io_core_out_i[i]}),
			.so_o(chain[IN_COUNT+i+1]), .upd_o({upd_oe[i], upd_out[i]}));
	end
	for (genvar i = 0; i < MC_COUNT; i++) begin : g_mc
		boundary_cell #(.NCAP(MC_CAP), .NUPD(1)) u_cell (
			.sys_clk_i(sys_clk_i), .rst_b_i(rst_sys_b), .ce_i(ce_i), .ctrl_i(ctrl),
			.si_i(chain[IN_COUNT+IO_COUNT+i]), .cap_i(mc_i[i]),
			.so_o(chain[IN_COUNT+IO_COUNT+i+1]), .upd_o(mc_upd[i]));
	end

	always_comb begin
		case (ir)
			IR_EXTEST, IR_SAMPLE: dr_out = chain[CELLS];
			IR_IDCODE:            dr_out = id_sr[0];
			IR_PROGRAM:           dr_out = prog_sr[0];
			default:              dr_out = byp;
		endcase
	end

	always_comb begin
		next_state      = state;
		next_ir         = ir;
		next_ir_sr      = ir_sr;
		next_byp        = byp;
		next_id         = id_sr;
		next_prog       = prog_sr;
		next_prog_word  = prog_word_o;
		next_prog_valid = 1'b0;
		next_tdo        = tdo_q;
		next_tdo_oe_b   = tdo_oe_b;
		if (!port_en_i) begin
			next_state    = ST_RESET;
			next_ir       = IR_RESET;
			next_tdo_oe_b = 1'b1;
		end else if (rise) begin
			next_state = tap_next(state, pins.tms);
			case (state)
				ST_RESET:  next_ir = IR_RESET;
				ST_CAP_IR: next_ir_sr = IR_CAPTURE;
				ST_SH_IR:  next_ir_sr = {pins.tdi, ir_sr[IR_W-1:1]};
				ST_UP_IR:  next_ir = legal_ir(ir_sr);
				ST_CAP_DR: begin
					next_byp = 1'b0;
					next_id  = ID_CODE;
				end
				ST_SH_DR: begin
					next_byp  = pins.tdi;
					next_id   = {pins.tdi, id_sr[ID_W-1:1]};
					next_prog = {pins.tdi, prog_sr[PROG_W-1:1]};
				end
				ST_UP_DR: begin
					if (ir == IR_PROGRAM) begin
						next_prog_word  = prog_sr;
						next_prog_valid = 1'b1;
					end
				end
				default: ;
			endcase
		end else if (fall) begin
			// data-out changes on the falling test clock so the tester samples it stable
			next_tdo_oe_b = !(state == ST_SH_DR || state == ST_SH_IR);
			next_tdo      = (state == ST_SH_IR) ? ir_sr[0] : dr_out;
		end
	end

	always_ff @(posedge sys_clk_i or negedge rst_sys_b) begin
		if (!rst_sys_b) begin
			state        <= ST_RESET;
			ir           <= IR_RESET;
			ir_sr        <= '0;
			byp          <= 1'b0;
			id_sr        <= '0;
			prog_sr      <= '0;
			prog_word_o  <= '0;
			prog_valid_o <= 1'b0;
			tdo_q        <= 1'b0;
			tdo_oe_b     <= 1'b1;
		end else if (ce_i) begin
			state        <= next_state;
			ir           <= next_ir;
			ir_sr        <= next_ir_sr;
			byp          <= next_byp;
			id_sr        <= next_id;
			prog_sr      <= next_prog;
			prog_word_o  <= next_prog_word;
			prog_valid_o <= next_prog_valid;
			tdo_q        <= next_tdo;
			tdo_oe_b     <= next_tdo_oe_b;
		end
	end

	logic [3:0]          next_tp_out, next_tp_oe_b, next_tp_in;
	logic [IO_COUNT-1:0] next_io_out, next_io_oe_b;
	logic                next_pu;

	// one extra register on every pin path keeps all outputs flop-driven
	always_comb begin
		next_tp_out  = port_en_i ? {tdo_q, 3'h0} : tp_core_out_i;
		next_tp_oe_b = port_en_i ? {tdo_oe_b, 3'h7} : ~tp_core_oe_i;
		next_tp_in   = port_en_i ? 4'h0 : s2[3:0];
		next_io_out  = extest ? upd_out : io_core_out_i;
		next_io_oe_b = extest ? ~upd_oe : ~io_core_oe_i;
		next_pu      = port_en_i && pu_sel_i;
	end

	always_ff @(posedge sys_clk_i or negedge rst_sys_b) begin
		if (!rst_sys_b) begin
			tp_pin_out_o  <= 4'h0;
			tp_pin_oe_b_o <= 4'hF;
			tp_core_in_o  <= 4'h0;
			in_core_o     <= '0;
			io_pin_out_o  <= '0;
			io_pin_oe_b_o <= '1;
			io_core_in_o  <= '0;
			mc_test_o     <= '0;
			mc_force_o    <= 1'b0;
			tms_pu_o      <= 1'b0;
			tdi_pu_o      <= 1'b0;
		end else if (ce_i) begin
			tp_pin_out_o  <= next_tp_out;
			tp_pin_oe_b_o <= next_tp_oe_b;
			tp_core_in_o  <= next_tp_in;
			in_core_o     <= s2[4 +: IN_COUNT];
			io_pin_out_o  <= next_io_out;
			io_pin_oe_b_o <= next_io_oe_b;
			io_core_in_o  <= s2[4+IN_COUNT +: IO_COUNT];
			mc_test_o     <= mc_upd;
			mc_force_o    <= extest;
			tms_pu_o      <= next_pu;
			tdi_pu_o      <= next_pu;
		end
	end

	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (!rst_sys_b);

	sequence s_up_ir;
		ce_i && port_en_i && rise && state == ST_UP_IR;
	endsequence
	sequence s_cap_dr(logic [IR_W-1:0] op);
		ce_i && port_en_i && rise && state == ST_CAP_DR && ir == op;
	endsequence

	AST_POWERUP_RESET: assert property (@(posedge sys_clk_i) $rose(rst_sys_b) |-> state == ST_RESET)
		else $error("port state machine not in reset after power-up");
	AST_IR_DECODE: assert property (s_up_ir |=> ir == legal_ir($past(ir_sr)))
		else $error("instruction not decoded from shifted opcode");
	AST_BYPASS_CLEAR: assert property (s_cap_dr(IR_BYPASS) |=> byp == 1'b0)
		else $error("bypass bit not cleared on capture");
	AST_ID_LOAD: assert property (s_cap_dr(IR_IDCODE) |=> id_sr == ID_CODE)
		else $error("identification word not loaded on capture");
	AST_CTRL_INTERNAL: assert property (ctrl.capture |-> rise && state == ST_CAP_DR && sel_bsr)
		else $error("cell capture outside capture state");
	AST_TDO_SHIFT: assert property (ce_i && port_en_i && fall && state == ST_SH_DR |=>
			(tdo_q == $past(dr_out) && !tdo_oe_b) and (ce_i && port_en_i |=> tp_pin_out_o[TP_TDO] == $past(tdo_q)))
		else $error("data-out pin not following the selected path");
	AST_DISABLED: assert property (ce_i && !port_en_i |=> state == ST_RESET &&
			tp_pin_oe_b_o == ~$past(tp_core_oe_i))
		else $error("test pins not released to user logic");
	AST_PROGRAM: assert property (ce_i && port_en_i && rise && state == ST_UP_DR && ir == IR_PROGRAM |=>
			prog_valid_o && prog_word_o == $past(prog_sr) ##1 (ce_i ? !prog_valid_o : 1'b1))
		else $error("programming word not delivered as one pulse");
	AST_PULLUP: assert property (ce_i |=> tms_pu_o == $past(port_en_i && pu_sel_i) && tdi_pu_o == tms_pu_o)
		else $error("pull-up enable does not follow the option");
	AST_EXTEST_DRIVE: assert property (ce_i && extest |=> io_pin_out_o == $past(upd_out))
		else $error("pins not driven from update stages in extest");
endmodule // boundary_scan_test_port

// file: scan_partner.sv
// scan tester model: drives test clock, mode select and data-in, reads data-out
module scan_partner (
	input  wire logic clk_i,
	input  wire logic tdo_i,
	output logic      tck_o,
	output logic      tms_o,
	output logic      tdi_o
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		tck_o = 1'h0;
		tms_o = 1'h1;
		tdi_o = 1'h0;
	end
	// one test clock period of 160 ns; data-out taken just before the rise
	task automatic tbit(input logic m, input logic d, output logic q);
		tms_o <= m;
		tdi_o <= d;
		repeat (8) @(posedge clk_i);
		q = tdo_i;
		tck_o <= 1'h1;
		repeat (8) @(posedge clk_i);
		tck_o <= 1'h0;
	endtask
	// clock stands low between frames; starts and ends in idle
	task automatic scan(input logic ir, input int n, input logic [31:0] w, output logic [31:0] r);
		logic q;
		r = '0;
		tbit(1'h1, 1'h0, q);
		if (ir)
			tbit(1'h1, 1'h0, q);
		tbit(1'h0, 1'h0, q);
		tbit(1'h0, 1'h0, q);
		for (int j = 0; j < n; j++) begin
			tbit(j == n - 1, w[j], q);
			r[j] = q;
		end
		tbit(1'h1, 1'h0, q);
		tbit(1'h0, 1'h0, q);
	endtask
endmodule // scan_partner

// file: boundary_scan_test_port_tb_top.sv
// self-checking bench for the boundary-scan test port
module boundary_scan_test_port_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	import scan_port_pkg::*;
	localparam int IO = 4;
	localparam int IN = 4;
	localparam int MC = 2;
	localparam int PW = 8;
	localparam int L  = IN + 3 * IO + MC;
	logic          sys_clk_i = 1'h0;
	logic          rst_b_i = 1'h0;
	logic          port_en_i = 1'h1;
	logic          pu_sel_i = 1'h0;
	logic [3:0]    core_out = 4'h0;
	logic [3:0]    core_oe = 4'h0;
	logic [IN-1:0] in_pin = '0;
	logic [IO-1:0] io_pin = '0, io_out = '0, io_oe = '0;
	logic [MC-1:0] mc = '0;
	logic [3:0]    pin_in, pin_out, pin_oe_b, core_in;
	logic [IN-1:0] in_core;
	logic [IO-1:0] pad_out, pad_oe_b, io_core_in;
	logic [MC-1:0] mc_test;
	logic          mc_force, tms_pu, tdi_pu, prog_valid, tck, tms, tdi, q;
	logic          last3 = 1'h0;
	logic [PW-1:0] prog_word, pword;
	logic [2:0]    drv;
	logic [31:0]   r, w, e, st = 32'h35;
	int            n_mismatch = 0, checks = 0, npulse = 0;
	assign drv = {tdi, tms, tck};
	// a released data-out pad shows the inverse of its last level, not a held value
	assign pin_in = {pin_oe_b[3] ? ~last3 : pin_out[3], (drv & pin_oe_b[2:0]) | (pin_out[2:0] & ~pin_oe_b[2:0])};
	always #5 sys_clk_i = ~sys_clk_i;
	always @(posedge sys_clk_i) begin
		last3 <= pin_in[3];
		if (prog_valid === 1'h1) begin
			npulse++;
			pword <= prog_word;
		end
	end
	boundary_scan_test_port #(.IO_COUNT(IO), .IN_COUNT(IN), .MC_COUNT(MC), .PROG_W(PW), .ID_CODE(ID_CODE_DEFAULT))
	u_boundary_scan_test_port (
		.sys_clk_i    (sys_clk_i),
		.rst_b_i      (rst_b_i),
		.ce_i         (1'h1),
		.port_en_i    (port_en_i),
		.pu_sel_i     (pu_sel_i),
		.tp_pin_i     (pin_in),
		.tp_core_out_i(core_out),
		.tp_core_oe_i (core_oe),
		.tp_pin_out_o (pin_out),
		.tp_pin_oe_b_o(pin_oe_b),
		.tp_core_in_o (core_in),
		.in_pin_i     (in_pin),
		.in_core_o    (in_core),
		.io_pin_i     (io_pin),
		.io_core_out_i(io_out),
		.io_core_oe_i (io_oe),
		.io_pin_out_o (pad_out),
		.io_pin_oe_b_o(pad_oe_b),
		.io_core_in_o (io_core_in),
		.mc_i         (mc),
		.mc_test_o    (mc_test),
		.mc_force_o   (mc_force),
		.tms_pu_o     (tms_pu),
		.tdi_pu_o     (tdi_pu),
		.prog_word_o  (prog_word),
		.prog_valid_o (prog_valid)
	);
	scan_partner u_scan_partner (
		.clk_i(sys_clk_i),
		.tdo_i(pin_in[3]),
		.tck_o(tck),
		.tms_o(tms),
		.tdi_o(tdi)
	);
	function automatic logic [31:0] rnd();
		st = st ^ (st << 13);
		st = st ^ (st >> 17);
		st = st ^ (st << 5);
		return st;
	endfunction
	// value a capture should load at chain position p, counted from data-in
	function automatic logic cap_at(input int p);
		int k;
		k = p - IN;
		if (p < IN)
			return in_pin[p];
		if (k < 3 * IO)
			return (k % 3 == 0) ? io_out[k/3] : (k % 3 == 1) ? io_oe[k/3] : io_pin[k/3];
		return mc[k - 3 * IO];
	endfunction
	task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
		checks++;
		if (g !== x) begin
			n_mismatch++;
			$display("FAIL %s expected %h seen %h", nm, x, g);
		end
	endtask
	task automatic ir_load(input logic [3:0] op);
		u_scan_partner.scan(1'h1, 4, {28'h0, op}, r);
		chk("ir capture", IR_CAPTURE, r);
	endtask
	// first bit shifted ends at the far end of the chain
	task automatic ext_chk(input logic [31:0] v);
		for (int i = 0; i < IO; i++) begin
			chk("pad out", v[L-1-IN-3*i], pad_out[i]);
			chk("pad oe_b", !v[L-2-IN-3*i], pad_oe_b[i]);
		end
		for (int m = 0; m < MC; m++)
			chk("mc test", v[L-1-IN-3*IO-m], mc_test[m]);
		chk("mc force", 1'h1, mc_force);
	endtask
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", checks, n_mismatch);
		if (n_mismatch == 0 && checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	initial begin
		repeat (20) @(posedge sys_clk_i);
		chk("oe_b in reset", 4'hF, pin_oe_b);
		chk("io oe_b in reset", {IO{1'h1}}, pad_oe_b);
		rst_b_i <= 1'h1;
		repeat (6) @(posedge sys_clk_i);
		u_scan_partner.tbit(1'h0, 1'h0, q);
		u_scan_partner.scan(1'h0, 32, 32'h0, r);
		chk("id after power-up", ID_CODE_DEFAULT, r);
		$display("test power-up id done");
		ir_load(IR_IDCODE);
		u_scan_partner.scan(1'h0, 32, rnd(), r);
		chk("id instruction", ID_CODE_DEFAULT, r);
		// unsupported opcode 5 must behave as bypass
		for (int k = 0; k < 2; k++) begin
			ir_load(k == 0 ? IR_BYPASS : 4'h5);
			w = rnd();
			u_scan_partner.scan(1'h0, 8, w, r);
			chk("bypass data", {w[6:0], 1'h0}, r);
		end
		$display("test bypass done");
		w = rnd();
		{mc, io_oe, io_out, io_pin, in_pin} <= w[L-1:0];
		ir_load(IR_SAMPLE);
		w = rnd();
		u_scan_partner.scan(1'h0, L, w, r);
		e = '0;
		for (int j = 0; j < L; j++)
			e[j] = cap_at(L - 1 - j);
		chk("sample chain", e, r);
		chk("pads on core", io_out, pad_out);
		chk("oe on core", IO'(~io_oe), pad_oe_b);
		chk("io core in", io_pin, io_core_in);
		chk("in core", in_pin, in_core);
		chk("no force", 1'h0, mc_force);
		$display("test sample done");
		ir_load(IR_EXTEST);
		ext_chk(w);
		w = rnd();
		u_scan_partner.scan(1'h0, L, w, r);
		ext_chk(w);
		ir_load(IR_BYPASS);
		chk("force off", 1'h0, mc_force);
		$display("test extest done");
		ir_load(IR_PROGRAM);
		npulse = 0;
		w = rnd();
		u_scan_partner.scan(1'h0, PW, w, r);
		chk("prog pulses", 1, npulse);
		chk("prog word", w[PW-1:0], pword);
		$display("test programming done");
		for (int k = 0; k < 4; k++) begin
			{port_en_i, pu_sel_i} <= 2'(k);
			repeat (3) @(posedge sys_clk_i);
			chk("tms pull-up", k == 3, tms_pu);
			chk("tdi pull-up", k == 3, tdi_pu);
		end
		$display("test pull-up done");
		port_en_i <= 1'h0;
		for (int k = 0; k < 6; k++) begin
			w = rnd();
			core_out <= w[3:0];
			core_oe <= w[7:4];
			u_scan_partner.tbit(w[8], w[9], q);
			repeat (6) @(posedge sys_clk_i);
			chk("user pin out", core_out, pin_out);
			chk("user pin oe_b", 4'(~core_oe), pin_oe_b);
			chk("user pin in", (drv & ~core_oe[2:0]) | (core_out[2:0] & core_oe[2:0]), core_in[2:0]);
		end
		core_oe <= 4'h0;
		port_en_i <= 1'h1;
		repeat (4) @(posedge sys_clk_i);
		u_scan_partner.tbit(1'h0, 1'h0, q);
		u_scan_partner.scan(1'h0, 32, 32'h0, r);
		chk("id after enable", ID_CODE_DEFAULT, r);
		$display("test port option done");
		// a reset in mid-run must drop the bypass instruction again
		ir_load(IR_BYPASS);
		rst_b_i <= 1'h0;
		repeat (3) @(posedge sys_clk_i);
		chk("oe_b in mid reset", 4'hF, pin_oe_b);
		chk("io oe_b in mid reset", {IO{1'h1}}, pad_oe_b);
		rst_b_i <= 1'h1;
		repeat (6) @(posedge sys_clk_i);
		u_scan_partner.tbit(1'h0, 1'h0, q);
		u_scan_partner.scan(1'h0, 32, 32'h0, r);
		chk("id after mid reset", ID_CODE_DEFAULT, r);
		$display("test mid-run reset done");
		wrap_up();
	end
	initial begin
		repeat (90000) @(posedge sys_clk_i);
		n_mismatch++;
		$display("FAIL run time expected end seen timeout");
		wrap_up();
	end
endmodule // boundary_scan_test_port_tb_top
